// [hpm_pkg.sv]
// Shared constants of the host-port interrupt routing and mailbox block
package hpm_pkg;
   // ************************************************
   // Register locations
   // ************************************************
   localparam logic [15:0] BREAKPOINT_ADDR = 16'h0140;
   localparam logic [15:0] ROUTING_ADDR    = 16'h0142;
   localparam logic [15:0] MSG1_ADDR       = 16'h0144;
   localparam logic [15:0] MSG2_ADDR       = 16'h0148;
   localparam logic [15:0] MAILBOX_ADDR    = 16'hc0c6;

   // ************************************************
   // Reset values and masks
   // ************************************************
   localparam logic [15:0] BREAKPOINT_RESET = 16'h0000;
   localparam logic [15:0] ROUTING_RESET    = 16'h1400;
   localparam logic [15:0] ROUTING_MASK     = 16'hffcf;
   localparam logic [15:0] MAILBOX_RESET    = 16'h0000;
   localparam logic [15:0] READ_ZERO        = 16'h0000;
   localparam logic [15:0] STATUS_RESET     = 16'h0000;

   // ************************************************
   // Routing word fields
   // ************************************************
   localparam int VBUS_TO_HOST   = 15;
   localparam int ID_TO_HOST     = 14;
   localparam int FRAME2_TO_HOST = 13;
   localparam int FRAME2_TO_CPU  = 12;
   localparam int FRAME1_TO_HOST = 11;
   localparam int FRAME1_TO_CPU  = 10;
   localparam int RESET2_TO_HOST = 9;
   localparam int SWAP_HIGH_BIT  = 8;
   localparam int RESUME2_TO_HOST = 7;
   localparam int RESUME1_TO_HOST = 6;
   localparam int DONE2_TO_HOST  = 3;
   localparam int DONE1_TO_HOST  = 2;
   localparam int RESET1_TO_HOST = 1;
   localparam int SWAP_LOW_BIT   = 0;

   // ************************************************
   // CPU-side interrupt vector positions
   // ************************************************
   localparam int CPU_VBUS    = 0;
   localparam int CPU_ID      = 1;
   localparam int CPU_FRAME2  = 2;
   localparam int CPU_FRAME1  = 3;
   localparam int CPU_RESET2  = 4;
   localparam int CPU_RESUME2 = 5;
   localparam int CPU_RESUME1 = 6;
   localparam int CPU_DONE2   = 7;
   localparam int CPU_DONE1   = 8;
   localparam int CPU_RESET1  = 9;
   localparam int CPU_IRQ_W   = 10;
endpackage

// [hpm_event_flag.sv]
// Sticky event flag with set winning over clear
`timescale 1ns/1ps
module hpm_event_flag (
   input  wire logic core_clk,
   input  wire logic reset,
   input  wire logic setEvent,
   input  wire logic clearEvent,
   output logic      flag
);
   // ************************************************
   // Flag storage
   // ************************************************
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         flag <= 1'b0;
      end else if (setEvent) begin
         flag <= 1'b1;
      end else if (clearEvent) begin
         flag <= 1'b0;
      end
   end
endmodule // hpm_event_flag

// [hpm_lane_swap.sv]
// Byte lane exchange on the host data path
`timescale 1ns/1ps
module hpm_lane_swap (
   input  wire logic [15:0] dataIn,
   input  wire logic        swapOn,
   output logic      [15:0] dataOut
);
   // ************************************************
   // Lane select
   // ************************************************
   always_comb begin
      if (swapOn) begin
         dataOut = {dataIn[7:0], dataIn[15:8]};
      end else begin
         dataOut = dataIn;
      end
   end
endmodule // hpm_lane_swap

// [hpm_host_port_irq.sv]
// Host-port breakpoint, interrupt routing, message and mailbox logic
//
// Summary of operation
// R1: Breakpoint word at 0x0140, host read/write, CPU read only.
// R2: Program counter matching a nonzero breakpoint raises breakpoint vector 127.
// R3: Breakpoint interrupt stays pending until zero is written there.
// R4: Routing word at 0x0142, host read/write, CPU read only.
// R5: Routed source drives host interrupt pin and host status word.
// R6: Routing picks destination only; engine enables decide firing.
// R7: Bit 15 routes VBUS, bit 14 routes ID interrupt to host.
// R8: Frame interrupts have separate host and CPU bits; CPU bits reset 1.
// R9: Firmware lets only one side clear a doubly routed frame interrupt.
// R10: Bits 9 and 1 route bus-reset of ports 2 and 1 to host.
// R11: Bits 7 and 6 route resume of ports 2 and 1 to host.
// R12: Bits 3 and 2 route transfer-done of engines 2 and 1 to host.
// R13: Software writes both swap bits with one value.
// R14: Swap '00' keeps byte lanes; swap '11' exchanges them.
// R15: Any CPU write to message word sets its flag and host interrupt.
// R16: Host read of a message location clears its flag.
// R17: Shared 16-bit mailbox at 0xC0C6, zero after reset.
// R18: CPU mailbox write asserts host pin; host mailbox read drops it.
// R19: Host mailbox write raises receive-full; CPU mailbox read clears.
// R20: Host mailbox read raises transmit-empty; CPU mailbox write clears.
// R21: Host pin is OR of routed sources, message flags, mailbox pending.
`timescale 1ns/1ps
module hpm_host_port_irq (
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic [15:0] hostAddr,
   input  wire logic        hostWrite,
   input  wire logic        hostRead,
   input  wire logic [15:0] hostWdata,
   output logic      [15:0] hostRdata,
   output logic      [15:0] hostStatus,
   output logic             hostIrqPin,
   input  wire logic [15:0] cpuAddr,
   input  wire logic        cpuWrite,
   input  wire logic        cpuRead,
   input  wire logic [15:0] cpuWdata,
   output logic      [15:0] cpuRdata,
   input  wire logic [15:0] cpuPc,
   output logic             breakpointVector,
   input  wire logic        rxFullEnable,
   input  wire logic        txEmptyEnable,
   output logic             mailboxRxFullIrq,
   output logic             mailboxTxEmptyIrq,
   input  wire logic        vbusIrq,
   input  wire logic        idIrq,
   input  wire logic        frame2Irq,
   input  wire logic        frame1Irq,
   input  wire logic        reset2Irq,
   input  wire logic        resume2Irq,
   input  wire logic        resume1Irq,
   input  wire logic        done2Irq,
   input  wire logic        done1Irq,
   input  wire logic        reset1Irq,
   output logic      [9:0]  cpuIrq
);
   // ************************************************
   // Storage and internal signals
   // ************************************************
   logic [15:0] breakpointAddr, routing, mailbox;
   logic [15:0] hostWordIn, hostWordOut, next_hostWord;
   logic [15:0] next_cpuRdata, next_status;
   logic [9:0]  next_cpuIrq;
   logic        next_hostIrq, swapOn, pcMatch, breakPending, routedAny;
   logic        hostWrBreak, hostRdBreak, hostWrRoute, hostRdRoute;
   logic        hostRdMsg1, hostRdMsg2, hostWrMbox, hostRdMbox;
   logic        cpuWrMsg1, cpuWrMsg2, cpuWrMbox, cpuRdMbox;
   logic        msg1Flag, msg2Flag, mboxOutFlag, mboxInFlag, txEmptyFlag;

   // ************************************************
   // Address decode
   // ************************************************
   assign hostWrBreak = hostWrite && (hostAddr == hpm_pkg::BREAKPOINT_ADDR);
   assign hostRdBreak = hostRead && (hostAddr == hpm_pkg::BREAKPOINT_ADDR);
   assign hostWrRoute = hostWrite && (hostAddr == hpm_pkg::ROUTING_ADDR);
   assign hostRdRoute = hostRead && (hostAddr == hpm_pkg::ROUTING_ADDR);
   assign hostRdMsg1  = hostRead && (hostAddr == hpm_pkg::MSG1_ADDR);
   assign hostRdMsg2  = hostRead && (hostAddr == hpm_pkg::MSG2_ADDR);
   assign hostWrMbox  = hostWrite && (hostAddr == hpm_pkg::MAILBOX_ADDR);
   assign hostRdMbox  = hostRead && (hostAddr == hpm_pkg::MAILBOX_ADDR);
   assign cpuWrMsg1   = cpuWrite && (cpuAddr == hpm_pkg::MSG1_ADDR);
   assign cpuWrMsg2   = cpuWrite && (cpuAddr == hpm_pkg::MSG2_ADDR);
   assign cpuWrMbox   = cpuWrite && (cpuAddr == hpm_pkg::MAILBOX_ADDR);
   assign cpuRdMbox   = cpuRead && (cpuAddr == hpm_pkg::MAILBOX_ADDR);

   // ************************************************
   // Host data lane swap
   // ************************************************
   // R14: lane exchange select
   assign swapOn = routing[hpm_pkg::SWAP_HIGH_BIT] &&
                   routing[hpm_pkg::SWAP_LOW_BIT];

   hpm_lane_swap u_swapIn (
      .dataIn  (hostWdata),
      .swapOn  (swapOn),
      .dataOut (hostWordIn)
   );

   // R14: read lanes exchanged
   hpm_lane_swap u_swapOut (
      .dataIn  (next_hostWord),
      .swapOn  (swapOn),
      .dataOut (hostWordOut)
   );

   // ************************************************
   // Breakpoint word
   // ************************************************
   // R1: host-only write path
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         breakpointAddr <= hpm_pkg::BREAKPOINT_RESET;
      end else if (hostWrBreak) begin
         breakpointAddr <= hostWordIn;
      end
   end
   // R2: program counter compare
   assign pcMatch = (cpuPc == breakpointAddr) &&
                    (breakpointAddr != hpm_pkg::READ_ZERO);
   // R3: pending until zero written
   hpm_event_flag u_breakFlag (
      .core_clk   (core_clk),
      .reset      (reset),
      .setEvent   (pcMatch),
      .clearEvent (hostWrBreak && (hostWordIn == hpm_pkg::READ_ZERO)),
      .flag       (breakPending)
   );
   // R2: vector 127 output
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         breakpointVector <= 1'b0;
      end else begin
         breakpointVector <= breakPending;
      end
   end

   // ************************************************
   // Routing word
   // ************************************************
   // R4: host write, CPU read only
   // R8: CPU frame bits reset to one
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         routing <= hpm_pkg::ROUTING_RESET;
      end else if (hostWrRoute) begin
         routing <= hostWordIn & hpm_pkg::ROUTING_MASK;
      end
   end

   // ************************************************
   // Message flags
   // ************************************************
   // R15: write sets engine 1 flag
   // R16: host read clears it
   hpm_event_flag u_msg1Flag (
      .core_clk   (core_clk),
      .reset      (reset),
      .setEvent   (cpuWrMsg1),
      .clearEvent (hostRdMsg1),
      .flag       (msg1Flag)
   );

   // R15: write sets engine 2 flag
   // R16: host read clears it
   hpm_event_flag u_msg2Flag (
      .core_clk   (core_clk),
      .reset      (reset),
      .setEvent   (cpuWrMsg2),
      .clearEvent (hostRdMsg2),
      .flag       (msg2Flag)
   );

   // ************************************************
   // Shared mailbox
   // ************************************************
   // R17: shared word, zero at reset
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         mailbox <= hpm_pkg::MAILBOX_RESET;
      end else if (hostWrMbox) begin
         mailbox <= hostWordIn;
      end else if (cpuWrMbox) begin
         mailbox <= cpuWdata;
      end
   end
   // R18: outgoing data waiting
   hpm_event_flag u_mboxOut (
      .core_clk   (core_clk),
      .reset      (reset),
      .setEvent   (cpuWrMbox),
      .clearEvent (hostRdMbox),
      .flag       (mboxOutFlag)
   );
   // R19: receive-full flag
   hpm_event_flag u_mboxIn (
      .core_clk   (core_clk),
      .reset      (reset),
      .setEvent   (hostWrMbox),
      .clearEvent (cpuRdMbox),
      .flag       (mboxInFlag)
   );
   // R20: transmit-empty flag
   hpm_event_flag u_txEmpty (
      .core_clk   (core_clk),
      .reset      (reset),
      .setEvent   (hostRdMbox),
      .clearEvent (cpuWrMbox),
      .flag       (txEmptyFlag)
   );

   // R19: gated receive-full interrupt
   // R20: gated transmit-empty interrupt
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         mailboxRxFullIrq  <= 1'b0;
         mailboxTxEmptyIrq <= 1'b0;
      end else begin
         mailboxRxFullIrq  <= mboxInFlag && rxFullEnable;
         mailboxTxEmptyIrq <= txEmptyFlag && txEmptyEnable;
      end
   end

   // ************************************************
   // Interrupt routing
   // ************************************************
   // R5: routed sources into status
   // R6: sources arrive already enabled
   always_comb begin
      next_status = hpm_pkg::STATUS_RESET;
      // R7: VBUS and ID to host
      next_status[15] = vbusIrq && routing[hpm_pkg::VBUS_TO_HOST];
      next_status[14] = idIrq && routing[hpm_pkg::ID_TO_HOST];
      // R8: frame host bits
      next_status[12] = frame2Irq && routing[hpm_pkg::FRAME2_TO_HOST];
      next_status[10] = frame1Irq && routing[hpm_pkg::FRAME1_TO_HOST];
      // R10: bus-reset to host
      next_status[9]  = reset2Irq && routing[hpm_pkg::RESET2_TO_HOST];
      next_status[8]  = mboxInFlag;
      // R11: resume to host
      next_status[7]  = resume2Irq && routing[hpm_pkg::RESUME2_TO_HOST];
      next_status[6]  = resume1Irq && routing[hpm_pkg::RESUME1_TO_HOST];
      next_status[5]  = msg2Flag;
      next_status[4]  = msg1Flag;
      // R12: transfer-done to host
      next_status[3]  = done2Irq && routing[hpm_pkg::DONE2_TO_HOST];
      next_status[2]  = done1Irq && routing[hpm_pkg::DONE1_TO_HOST];
      next_status[1]  = reset1Irq && routing[hpm_pkg::RESET1_TO_HOST];
      next_status[0]  = mboxOutFlag;
   end
   // R5: unrouted sources stay with CPU
   always_comb begin
      next_cpuIrq = '0;
      next_cpuIrq[hpm_pkg::CPU_VBUS]    = vbusIrq &&
                                          !routing[hpm_pkg::VBUS_TO_HOST];
      next_cpuIrq[hpm_pkg::CPU_ID]      = idIrq &&
                                          !routing[hpm_pkg::ID_TO_HOST];
      // R8: independent CPU frame bits
      // R9: both sides may see frame
      next_cpuIrq[hpm_pkg::CPU_FRAME2]  = frame2Irq &&
                                          routing[hpm_pkg::FRAME2_TO_CPU];
      next_cpuIrq[hpm_pkg::CPU_FRAME1]  = frame1Irq &&
                                          routing[hpm_pkg::FRAME1_TO_CPU];
      next_cpuIrq[hpm_pkg::CPU_RESET2]  = reset2Irq &&
                                          !routing[hpm_pkg::RESET2_TO_HOST];
      next_cpuIrq[hpm_pkg::CPU_RESUME2] = resume2Irq &&
                                          !routing[hpm_pkg::RESUME2_TO_HOST];
      next_cpuIrq[hpm_pkg::CPU_RESUME1] = resume1Irq &&
                                          !routing[hpm_pkg::RESUME1_TO_HOST];
      next_cpuIrq[hpm_pkg::CPU_DONE2]   = done2Irq &&
                                          !routing[hpm_pkg::DONE2_TO_HOST];
      next_cpuIrq[hpm_pkg::CPU_DONE1]   = done1Irq &&
                                          !routing[hpm_pkg::DONE1_TO_HOST];
      next_cpuIrq[hpm_pkg::CPU_RESET1]  = reset1Irq &&
                                          !routing[hpm_pkg::RESET1_TO_HOST];
   end

   // R21: OR of host-bound causes
   assign routedAny = |{next_status[15:9], next_status[7:6], next_status[3:1]};
   // R15: message flags drive pin
   // R18: mailbox pending drives pin
   assign next_hostIrq = routedAny || msg1Flag || msg2Flag || mboxOutFlag;
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         hostStatus <= hpm_pkg::STATUS_RESET;
         hostIrqPin <= 1'b0;
         cpuIrq     <= '0;
      end else begin
         hostStatus <= next_status;
         hostIrqPin <= next_hostIrq;
         cpuIrq     <= next_cpuIrq;
      end
   end

   // ************************************************
   // Read data
   // ************************************************
   always_comb begin
      next_hostWord = hpm_pkg::READ_ZERO;
      if (hostRdBreak) begin
         next_hostWord = breakpointAddr;
      end else if (hostRdRoute) begin
         next_hostWord = routing;
      end else if (hostRdMbox) begin
         next_hostWord = mailbox;
      end
   end

   // R1: CPU reads breakpoint
   // R4: CPU reads routing
   always_comb begin
      next_cpuRdata = hpm_pkg::READ_ZERO;
      if (cpuRead) begin
         unique case (cpuAddr)
            hpm_pkg::BREAKPOINT_ADDR: next_cpuRdata = breakpointAddr;
            hpm_pkg::ROUTING_ADDR:    next_cpuRdata = routing;
            hpm_pkg::MAILBOX_ADDR:    next_cpuRdata = mailbox;
            default:                  next_cpuRdata = hpm_pkg::READ_ZERO;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         hostRdata <= hpm_pkg::READ_ZERO;
         cpuRdata  <= hpm_pkg::READ_ZERO;
      end else begin
         if (hostRead) begin
            hostRdata <= hostWordOut;
         end
         if (cpuRead) begin
            cpuRdata <= next_cpuRdata;
         end
      end
   end
endmodule // hpm_host_port_irq

// [hpm_host_port_irq_sva.sv]
// Port checks of the host-port interrupt routing block
`timescale 1ns/1ps
module hpm_host_port_irq_sva (
   input wire logic        core_clk,
   input wire logic        reset,
   input wire logic [15:0] hostAddr,
   input wire logic        hostWrite,
   input wire logic        hostRead,
   input wire logic [15:0] hostWdata,
   input wire logic [15:0] hostStatus,
   input wire logic        hostIrqPin,
   input wire logic [15:0] cpuAddr,
   input wire logic        cpuWrite,
   input wire logic        cpuRead,
   input wire logic        breakpointVector,
   input wire logic        rxFullEnable,
   input wire logic        txEmptyEnable,
   input wire logic        mailboxRxFullIrq,
   input wire logic        mailboxTxEmptyIrq,
   input wire logic        vbusIrq,
   input wire logic [9:0]  cpuIrq
);
   // ****************************************
   // Decodes
   // ****************************************
   wire hMbWr = hostWrite && hostAddr == hpm_pkg::MAILBOX_ADDR;
   wire hMbRd = hostRead && hostAddr == hpm_pkg::MAILBOX_ADDR;
   wire cMbWr = cpuWrite && cpuAddr == hpm_pkg::MAILBOX_ADDR;
   wire cMbRd = cpuRead && cpuAddr == hpm_pkg::MAILBOX_ADDR;
   wire cMsg1 = cpuWrite && cpuAddr == hpm_pkg::MSG1_ADDR;
   wire hMsg1 = hostRead && hostAddr == hpm_pkg::MSG1_ADDR;
   wire hZero = hostWrite && hostWdata == 16'h0000
                && hostAddr == hpm_pkg::BREAKPOINT_ADDR;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);
   // ****************************************
   // Properties
   // ****************************************
   sequence s_hostMbWr;
      hMbWr;
   endsequence
   sequence s_hostMbRd;
      hMbRd;
   endsequence
   property p_rxFull;
      s_hostMbWr ##1 (rxFullEnable && !cMbRd) |=> mailboxRxFullIrq;
   endproperty
   a_rxFull: assert property (p_rxFull) else $error("rx full late");
   property p_rxClr;
      cMbRd && !hMbWr |=> ##1 !mailboxRxFullIrq;
   endproperty
   a_rxClr: assert property (p_rxClr) else $error("rx full kept");
   property p_txEmpty;
      s_hostMbRd ##1 (txEmptyEnable && !cMbWr) |=> mailboxTxEmptyIrq;
   endproperty
   a_txEmpty: assert property (p_txEmpty) else $error("tx empty");
   property p_statusIn;
      s_hostMbWr |=> ##1 hostStatus[8];
   endproperty
   a_statusIn: assert property (p_statusIn) else $error("in flag");
   property p_mbOut;
      cMbWr |=> ##1 (hostIrqPin && hostStatus[0]);
   endproperty
   a_mbOut: assert property (p_mbOut) else $error("out flag");
   property p_msgSet;
      cMsg1 |=> ##1 (hostStatus[4] && hostIrqPin);
   endproperty
   a_msgSet: assert property (p_msgSet) else $error("msg set");
   property p_msgClr;
      hMsg1 && !cMsg1 |=> ##1 !hostStatus[4];
   endproperty
   a_msgClr: assert property (p_msgClr) else $error("msg clear");
   property p_pinOr;
      hostIrqPin == (|{hostStatus[15:9], hostStatus[7:0]});
   endproperty
   a_pinOr: assert property (p_pinOr) else $error("pin cause");
   property p_vbusRoute;
      hostStatus[15] |-> $past(vbusIrq) && !cpuIrq[hpm_pkg::CPU_VBUS];
   endproperty
   a_vbusRoute: assert property (p_vbusRoute) else $error("vbus");
   property p_bpHold;
      breakpointVector && !hZero && !$past(hZero) |=> breakpointVector;
   endproperty
   a_bpHold: assert property (p_bpHold) else $error("bp dropped");
endmodule // hpm_host_port_irq_sva

bind hpm_host_port_irq hpm_host_port_irq_sva i_sva (
   .core_clk(core_clk), .reset(reset), .hostAddr(hostAddr),
   .hostWrite(hostWrite), .hostRead(hostRead), .hostWdata(hostWdata),
   .hostStatus(hostStatus), .hostIrqPin(hostIrqPin),
   .cpuAddr(cpuAddr), .cpuWrite(cpuWrite), .cpuRead(cpuRead),
   .breakpointVector(breakpointVector), .rxFullEnable(rxFullEnable),
   .txEmptyEnable(txEmptyEnable), .mailboxRxFullIrq(mailboxRxFullIrq),
   .mailboxTxEmptyIrq(mailboxTxEmptyIrq), .vbusIrq(vbusIrq),
   .cpuIrq(cpuIrq)
);

// [hpm_host_model.sv]
// External host processor model on the host port
`timescale 1ns/1ps
module hpm_host_model (
   input  wire logic        core_clk,
   input  wire logic [15:0] hostRdata,
   output logic      [15:0] hostAddr,
   output logic             hostWrite,
   output logic             hostRead,
   output logic      [15:0] hostWdata
);
   initial begin
      hostAddr  = 16'hffff;
      hostWrite = 1'b0;
      hostRead  = 1'b0;
      hostWdata = 16'hffff;
   end
   task automatic hwr(input logic [15:0] a, input logic [15:0] d);
      @(posedge core_clk);
      hostAddr  <= a;
      hostWdata <= (a == hpm_pkg::ROUTING_ADDR) ? {d[15:1], d[8]} : d;
      hostWrite <= 1'b1;
      @(posedge core_clk);
      hostWrite <= 1'b0;
      hostAddr  <= ~a;
      hostWdata <= ~d;
   endtask
   task automatic hrd(input logic [15:0] a, output logic [15:0] d);
      @(posedge core_clk);
      hostAddr <= a;
      hostRead <= 1'b1;
      @(posedge core_clk);
      hostRead <= 1'b0;
      hostAddr <= ~a;
      #1 d = hostRdata;
   endtask
   task automatic bpClear();
      hwr(hpm_pkg::BREAKPOINT_ADDR, 16'h0000);
   endtask
endmodule // hpm_host_model

// [hpm_host_port_irq_tb.sv]
// Self-checking bench of the host-port interrupt routing block
`timescale 1ns/1ps
module hpm_host_port_irq_tb;
   logic        core_clk = 1'b0;
   logic        reset = 1'b1;
   logic [15:0] hostAddr, hostWdata, hostRdata, hostStatus, cpuRdata, rd;
   logic        hostWrite, hostRead, hostIrqPin, breakpointVector;
   logic        mailboxRxFullIrq, mailboxTxEmptyIrq;
   logic [15:0] cpuAddr = 16'hffff;
   logic [15:0] cpuWdata = 16'hffff;
   logic [15:0] cpuPc = 16'hffff;
   logic        cpuWrite = 1'b0;
   logic        cpuRead = 1'b0;
   logic        rxFullEnable = 1'b1;
   logic        txEmptyEnable = 1'b1;
   logic [9:0]  src = 10'h004;
   logic [9:0]  cpuIrq;
   int          n_fail = 0;
   int          n_compared = 0;
   int          hb [10] = '{15, 14, 13, 11, 9, 7, 6, 3, 2, 1};
   int          sb [10] = '{15, 14, 12, 10, 9, 7, 6, 3, 2, 1};
   logic [15:0] ra [5] = '{hpm_pkg::BREAKPOINT_ADDR, hpm_pkg::ROUTING_ADDR,
      hpm_pkg::MSG1_ADDR, hpm_pkg::MAILBOX_ADDR, 16'h0200};
   logic [15:0] rv [5] = '{16'h0000, 16'h1400, 16'h0000, 16'h0000, 16'h0000};
   logic [15:0] ma [2] = '{hpm_pkg::MSG1_ADDR, hpm_pkg::MSG2_ADDR};
   always #2.5 core_clk = ~core_clk;
   hpm_host_model i_host (.core_clk(core_clk), .hostRdata(hostRdata),
      .hostAddr(hostAddr), .hostWrite(hostWrite), .hostRead(hostRead),
      .hostWdata(hostWdata));
   hpm_host_port_irq i_dut (.core_clk(core_clk), .reset(reset),
      .hostAddr(hostAddr), .hostWrite(hostWrite), .hostRead(hostRead),
      .hostWdata(hostWdata), .hostRdata(hostRdata), .hostStatus(hostStatus),
      .hostIrqPin(hostIrqPin), .cpuAddr(cpuAddr), .cpuWrite(cpuWrite),
      .cpuRead(cpuRead), .cpuWdata(cpuWdata), .cpuRdata(cpuRdata),
      .cpuPc(cpuPc), .breakpointVector(breakpointVector),
      .rxFullEnable(rxFullEnable), .txEmptyEnable(txEmptyEnable),
      .mailboxRxFullIrq(mailboxRxFullIrq),
      .mailboxTxEmptyIrq(mailboxTxEmptyIrq), .vbusIrq(src[0]),
      .idIrq(src[1]), .frame2Irq(src[2]), .frame1Irq(src[3]),
      .reset2Irq(src[4]), .resume2Irq(src[5]), .resume1Irq(src[6]),
      .done2Irq(src[7]), .done1Irq(src[8]), .reset1Irq(src[9]),
      .cpuIrq(cpuIrq));
   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chkb(input logic g, input logic e);
      chk({15'h0000, g}, {15'h0000, e});
   endtask
   task automatic cwr(input logic [15:0] a, input logic [15:0] d);
      @(posedge core_clk);
      cpuAddr  <= a;
      cpuWdata <= d;
      cpuWrite <= 1'b1;
      @(posedge core_clk);
      cpuWrite <= 1'b0;
      cpuAddr  <= ~a;
   endtask
   task automatic crd(input logic [15:0] a, output logic [15:0] d);
      @(posedge core_clk);
      cpuAddr <= a;
      cpuRead <= 1'b1;
      @(posedge core_clk);
      cpuRead <= 1'b0;
      cpuAddr <= ~a;
      #1 d = cpuRdata;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic setSrc(input logic [9:0] v);
      @(posedge core_clk);
      src <= v;
   endtask
   task automatic stop_test();
      $display("compared=%0d failed=%0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      #100000;
      n_fail++;
      stop_test();
   end
   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      tick(2);
      chk({6'h00, cpuIrq}, 16'h0004);
      chk(hostStatus, 16'h0000);
      for (int i = 0; i < 5; i++) begin
         i_host.hrd(ra[i], rd);
         chk(rd, rv[i]);
      end
      for (int i = 0; i < 10; i++) begin
         i_host.hwr(hpm_pkg::ROUTING_ADDR, 16'h0001 << hb[i]);
         setSrc(10'h001 << i);
         tick(2);
         chk(hostStatus, 16'h0001 << sb[i]);
         chk({6'h00, cpuIrq}, 16'h0000);
      end
      i_host.hwr(hpm_pkg::ROUTING_ADDR, 16'hfefe);
      cwr(hpm_pkg::ROUTING_ADDR, 16'h0000);
      crd(hpm_pkg::ROUTING_ADDR, rd);
      chk(rd, 16'hfefe & hpm_pkg::ROUTING_MASK);
      setSrc(10'h3ff);
      tick(2);
      chk(hostStatus, 16'hd6ce);
      chk({6'h00, cpuIrq}, 16'h000c);
      chkb(hostIrqPin, 1'b1);
      setSrc(10'h000);
      tick(2);
      chk(hostStatus, 16'h0000);
      chkb(hostIrqPin, 1'b0);
      i_host.hwr(hpm_pkg::ROUTING_ADDR, 16'h0000);
      setSrc(10'h3ff);
      tick(2);
      chk({6'h00, cpuIrq}, 16'h03f3);
      setSrc(10'h000);
      i_host.hwr(hpm_pkg::ROUTING_ADDR, 16'h0101);
      i_host.hwr(hpm_pkg::MAILBOX_ADDR, 16'h1234);
      crd(hpm_pkg::MAILBOX_ADDR, rd);
      chk(rd, 16'h3412);
      i_host.hrd(hpm_pkg::MAILBOX_ADDR, rd);
      chk(rd, 16'h1234);
      i_host.hwr(hpm_pkg::ROUTING_ADDR, 16'h0000);
      i_host.hwr(hpm_pkg::MAILBOX_ADDR, 16'ha5c3);
      tick(1);
      chkb(mailboxRxFullIrq, 1'b1);
      chkb(hostStatus[8], 1'b1);
      crd(hpm_pkg::MAILBOX_ADDR, rd);
      chk(rd, 16'ha5c3);
      tick(1);
      chkb(mailboxRxFullIrq, 1'b0);
      cwr(hpm_pkg::MAILBOX_ADDR, 16'h5a5a);
      tick(1);
      chkb(mailboxTxEmptyIrq, 1'b0);
      chkb(hostIrqPin & hostStatus[0], 1'b1);
      i_host.hrd(hpm_pkg::MAILBOX_ADDR, rd);
      chk(rd, 16'h5a5a);
      tick(1);
      chkb(hostIrqPin, 1'b0);
      chkb(mailboxTxEmptyIrq, 1'b1);
      @(posedge core_clk);
      rxFullEnable <= 1'b0;
      i_host.hwr(hpm_pkg::MAILBOX_ADDR, 16'h1111);
      tick(1);
      chkb(mailboxRxFullIrq, 1'b0);
      @(posedge core_clk);
      rxFullEnable <= 1'b1;
      tick(1);
      chkb(mailboxRxFullIrq, 1'b1);
      crd(hpm_pkg::MAILBOX_ADDR, rd);
      for (int i = 0; i < 2; i++) begin
         cwr(ma[i], 16'h0000);
         tick(1);
         chk(hostStatus, 16'h0010 << i);
         chkb(hostIrqPin, 1'b1);
         i_host.hrd(ma[i], rd);
         chk(rd, 16'h0000);
         tick(1);
         chk(hostStatus, 16'h0000);
         chkb(hostIrqPin, 1'b0);
      end
      i_host.hwr(hpm_pkg::BREAKPOINT_ADDR, 16'h0200);
      tick(2);
      chkb(breakpointVector, 1'b0);
      @(posedge core_clk);
      cpuPc <= 16'h0200;
      @(posedge core_clk);
      cpuPc <= 16'hffff;
      tick(2);
      chkb(breakpointVector, 1'b1);
      cwr(hpm_pkg::BREAKPOINT_ADDR, 16'h0000);
      crd(hpm_pkg::BREAKPOINT_ADDR, rd);
      chk(rd, 16'h0200);
      tick(20);
      chkb(breakpointVector, 1'b1);
      i_host.bpClear();
      tick(2);
      chkb(breakpointVector, 1'b0);
      stop_test();
   end
endmodule // hpm_host_port_irq_tb
